// ### src/lws_pkg.sv
package lws_pkg;
    // Clock and hold timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_US = 500;
    localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned HOLD_MIN_US = 500;
    localparam int unsigned HOLD_MAX_US = 10000000;
    localparam int unsigned HOLD_MIN_TICKS = HOLD_MIN_US / TICK_US;
    localparam int unsigned HOLD_MAX_TICKS = HOLD_MAX_US / TICK_US;
    // Table sizes
    localparam int unsigned MAX_ENTRIES = 1002;
    localparam int unsigned RB_MAX = 16;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_HOLD_WR = 8'h0c;
    localparam logic [7:0] ADDR_HOLD_PTR = 8'h10;
    localparam logic [7:0] ADDR_RB_START = 8'h14;
    localparam logic [7:0] ADDR_RB_DATA = 8'h18;
    localparam logic [7:0] ADDR_STEP_CNT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    // Field positions
    localparam int unsigned CTRL_DIR_BIT = 0;
    localparam int unsigned CTRL_ORDER_BIT = 1;
    localparam int unsigned CTRL_QTY_BIT = 2;
    localparam int unsigned CMD_CLEAR_BIT = 0;
    localparam int unsigned CMD_VRUN_BIT = 1;
    localparam int unsigned CMD_CRUN_BIT = 2;
    localparam int unsigned CMD_STOP_BIT = 3;
    localparam int unsigned COUNT_REP_LSB = 0;
    localparam int unsigned COUNT_SKIP_LSB = 8;
    localparam int unsigned STAT_PASS_LSB = 8;
    localparam int unsigned STAT_POS_LSB = 16;
    // Reset values
    localparam logic [7:0] REP_RST = 8'h01;
    localparam logic [7:0] SKIP_RST = 8'h00;
    localparam logic [9:0] STEP_CNT_RST = 10'h000;
    // Types
    typedef logic [9:0] lws_loc_t;
    typedef logic [14:0] lws_tick_t;
    typedef enum logic [1:0] {LWS_IDLE, LWS_RUN, LWS_DONE} lws_state_e;
endpackage

// ### src/lws_hold_timer.sv
`timescale 1ns/100ps
`default_nettype none
module lws_hold_timer #(
    parameter int unsigned TICK_CYCLES = lws_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic load,
    input wire logic abort,
    input wire lws_pkg::lws_tick_t ticks,
    // Expiry, combinational in the last cycle of the hold
    output logic done
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_FULL = PW'(TICK_CYCLES - 1);
    localparam logic [PW-1:0] PRE_FIRST = PW'(TICK_CYCLES - 2);

    logic [PW-1:0] pre_q;
    lws_pkg::lws_tick_t left_q;
    logic busy_q;
    logic tick_w;

    assign tick_w = busy_q && (pre_q == '0);
    // Ends the hold exactly ticks*TICK_CYCLES after the step began
    assign done = tick_w && (left_q == 15'h0001);

    // First prescale shortened by the load cycle, keeping steps gapless
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            left_q <= '0;
            busy_q <= 1'b0;
        end else if (load) begin
            pre_q <= PRE_FIRST;
            left_q <= (ticks == '0) ? 15'h0001 : ticks;
            busy_q <= 1'b1;
        end else if (abort) begin
            busy_q <= 1'b0;
        end else if (tick_w) begin
            pre_q <= PRE_FULL;
            left_q <= left_q - 15'h0001;
            busy_q <= !done;
        end else if (busy_q) begin
            pre_q <= pre_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### src/lws_sequencer.sv
// Contract
// - Steps play ascending or descending per the direction bit.
// - Reset or list clear returns direction to ascending.
// - Direction applies to default and custom location order alike.
// - Direction reads back as stored.
// - Hold times kept within 0.0005 to 10 seconds; values outside are clamped to that range.
// - Hold times appended sequentially, at most 1002 entries.
// - Each hold time pairs with the step at the same location.
// - Step table drives voltage or current per the quantity selection.
// - Only location 0 written: that hold applies to every step.
// - Hold readback returns at most 16 entries from the start pointer.
// - Fill pointer reads the count written, which is the next location.
// - List clear zeroes every fill pointer.
// - Voltage or current run command starts the list; here only the one matching the quantity selection does.
// - Wrap from final to initial step jumps directly.
// - After the repetitions, stop holding the last executed step.
// - Descending runs end on location 0.
// - Steps follow with no gap.
// - Skip count omits leading steps on passes after the first.
// - Run time is repetitions times the sum of hold times per pass; with a skip count, passes after the first omit the skipped holds.
// - Skip count 0 to 255, ignored when descending.
// - Repetition count 0 to 255; zero repeats until stopped.
// - List clear also selects default order and repetition count one.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module lws_sequencer #(
    parameter int unsigned TICK_CYCLES = lws_pkg::TICK_CYCLES,
    parameter int unsigned MAX_ENTRIES = lws_pkg::MAX_ENTRIES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Custom order table lookup for the current position
    input wire lws_pkg::lws_loc_t custom_loc,
    // Step outputs
    output logic [9:0] step_position,
    output logic step_load,
    output logic use_current,
    output logic custom_order,
    output logic running,
    output logic list_done
);
    lws_pkg::lws_tick_t hold_mem [MAX_ENTRIES];
    lws_pkg::lws_state_e state_q;
    logic wr_q, dir_q, order_q, qty_q, load_q, hrdy_q;
    logic [7:0] addr_q, rep_q, skip_q, pass_q;
    logic [31:0] hrdata_q;
    logic [9:0] fill_q, rb_start_q, step_cnt_q, pos_q;
    logic [4:0] rb_idx_q;

    // Bus decode
    wire addr_ph = hsel && htrans[1] && hready;
    wire rd_ph = addr_ph && !hwrite;
    wire rb_rd = rd_ph && (haddr[7:0] == lws_pkg::ADDR_RB_DATA);
    wire wr_ctrl = wr_q && (addr_q == lws_pkg::ADDR_CTRL);
    wire wr_cmd = wr_q && (addr_q == lws_pkg::ADDR_CMD);
    wire wr_count = wr_q && (addr_q == lws_pkg::ADDR_COUNT);
    wire wr_hold = wr_q && (addr_q == lws_pkg::ADDR_HOLD_WR);
    wire wr_rbst = wr_q && (addr_q == lws_pkg::ADDR_RB_START);
    wire wr_steps = wr_q && (addr_q == lws_pkg::ADDR_STEP_CNT);
    wire clr = wr_cmd && hwdata[lws_pkg::CMD_CLEAR_BIT];
    wire stop = wr_cmd && hwdata[lws_pkg::CMD_STOP_BIT];
    wire vrun = wr_cmd && hwdata[lws_pkg::CMD_VRUN_BIT] && !qty_q;
    wire crun = wr_cmd && hwdata[lws_pkg::CMD_CRUN_BIT] && qty_q;
    wire start = (vrun || crun) && (step_cnt_q != '0) && !clr && !stop;
    wire fill_full = (fill_q == 10'(MAX_ENTRIES));

    // Hold value clamped to the legal range in ticks
    wire [14:0] hold_in = (hwdata[14:0] < 15'(lws_pkg::HOLD_MIN_TICKS)) ?
        15'(lws_pkg::HOLD_MIN_TICKS) : hwdata[14:0];
    wire [14:0] hold_clamped = (hwdata[31:15] != '0 ||
        hold_in > 15'(lws_pkg::HOLD_MAX_TICKS)) ?
        15'(lws_pkg::HOLD_MAX_TICKS) : hold_in;

    // Readback window
    wire [9:0] rb_loc = rb_start_q + 10'(rb_idx_q);
    wire rb_ok = (rb_idx_q < 5'(lws_pkg::RB_MAX)) && (rb_loc < fill_q);
    wire [14:0] rb_val = rb_ok ? hold_mem[rb_loc] : '0;

    // Hold lookup for the step now playing
    wire [9:0] loc = order_q ? custom_loc : pos_q;
    wire own_hold = (fill_q > 10'h001) && (loc < fill_q);
    wire [14:0] ticks = own_hold ? hold_mem[loc] :
        (fill_q == '0) ? 15'(lws_pkg::HOLD_MIN_TICKS) : hold_mem[0];

    // Step advance
    wire [9:0] last = step_cnt_q - 10'h001;
    wire at_end = dir_q ? (pos_q == '0) : (pos_q == last);
    wire skip_on = !dir_q && (skip_q != '0);
    wire [9:0] skip_pos = (10'(skip_q) > last) ? last : 10'(skip_q);
    wire [9:0] wrap_pos = dir_q ? last : (skip_on ? skip_pos : '0);
    wire [9:0] step_pos = dir_q ? pos_q - 10'h001 : pos_q + 10'h001;
    wire final_step = at_end && (rep_q != '0) && (pass_q == rep_q);
    wire [9:0] first_pos = dir_q ? last : '0;
    wire t_done;
    wire advance = (state_q == lws_pkg::LWS_RUN) && t_done && !start;

    lws_hold_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(load_q),
        .abort(clr || stop || (state_q != lws_pkg::LWS_RUN)),
        .ticks(ticks),
        .done(t_done)
    );

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = '0;
        if (haddr[7:0] == lws_pkg::ADDR_CTRL) begin
            rdata[lws_pkg::CTRL_DIR_BIT] = dir_q;
            rdata[lws_pkg::CTRL_ORDER_BIT] = order_q;
            rdata[lws_pkg::CTRL_QTY_BIT] = qty_q;
        end else if (haddr[7:0] == lws_pkg::ADDR_COUNT) begin
            rdata[lws_pkg::COUNT_REP_LSB +: 8] = rep_q;
            rdata[lws_pkg::COUNT_SKIP_LSB +: 8] = skip_q;
        end else if (haddr[7:0] == lws_pkg::ADDR_HOLD_PTR) begin
            rdata[9:0] = fill_q;
        end else if (haddr[7:0] == lws_pkg::ADDR_RB_START) begin
            rdata[9:0] = rb_start_q;
        end else if (haddr[7:0] == lws_pkg::ADDR_RB_DATA) begin
            rdata[14:0] = rb_val;
        end else if (haddr[7:0] == lws_pkg::ADDR_STEP_CNT) begin
            rdata[9:0] = step_cnt_q;
        end else if (haddr[7:0] == lws_pkg::ADDR_STATUS) begin
            rdata[0] = (state_q == lws_pkg::LWS_RUN);
            rdata[1] = (state_q == lws_pkg::LWS_DONE);
            rdata[lws_pkg::STAT_PASS_LSB +: 8] = pass_q;
            rdata[lws_pkg::STAT_POS_LSB +: 10] = pos_q;
        end
    end

    // Bus phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= '0;
            hrdata_q <= '0;
            hrdy_q <= 1'b0;
        end else begin
            wr_q <= addr_ph && hwrite;
            addr_q <= haddr[7:0];
            hrdata_q <= rd_ph ? rdata : '0;
            hrdy_q <= 1'b1;
        end
    end

    // Hold table storage, appended at the fill pointer
    always_ff @(posedge hclk) begin
        if (wr_hold && !fill_full && !clr) begin
            hold_mem[fill_q] <= hold_clamped;
        end
    end

    // Settings and pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_q <= 1'b0;
            order_q <= 1'b0;
            qty_q <= 1'b0;
            rep_q <= lws_pkg::REP_RST;
            skip_q <= lws_pkg::SKIP_RST;
            fill_q <= '0;
            rb_start_q <= '0;
            rb_idx_q <= '0;
            step_cnt_q <= lws_pkg::STEP_CNT_RST;
        end else if (clr) begin
            dir_q <= 1'b0;
            order_q <= 1'b0;
            rep_q <= lws_pkg::REP_RST;
            skip_q <= lws_pkg::SKIP_RST;
            fill_q <= '0;
            rb_start_q <= '0;
            rb_idx_q <= '0;
            step_cnt_q <= lws_pkg::STEP_CNT_RST;
        end else begin
            if (wr_ctrl) begin
                dir_q <= hwdata[lws_pkg::CTRL_DIR_BIT];
                order_q <= hwdata[lws_pkg::CTRL_ORDER_BIT];
                qty_q <= hwdata[lws_pkg::CTRL_QTY_BIT];
            end
            if (wr_count) begin
                rep_q <= hwdata[lws_pkg::COUNT_REP_LSB +: 8];
                skip_q <= hwdata[lws_pkg::COUNT_SKIP_LSB +: 8];
            end
            if (wr_hold && !fill_full) begin
                fill_q <= fill_q + 10'h001;
            end
            if (wr_rbst) begin
                rb_start_q <= hwdata[9:0];
                rb_idx_q <= '0;
            end else if (rb_rd && rb_idx_q < 5'(lws_pkg::RB_MAX)) begin
                rb_idx_q <= rb_idx_q + 5'h01;
            end
            if (wr_steps) begin
                step_cnt_q <= (hwdata[9:0] > 10'(MAX_ENTRIES)) ?
                    10'(MAX_ENTRIES) : hwdata[9:0];
            end
        end
    end

    // Sequencer state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= lws_pkg::LWS_IDLE;
            pos_q <= '0;
            pass_q <= '0;
            load_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (clr || stop) begin
                state_q <= lws_pkg::LWS_IDLE;
            end else if (start) begin
                state_q <= lws_pkg::LWS_RUN;
                pos_q <= first_pos;
                pass_q <= 8'h01;
                load_q <= 1'b1;
            end else if (advance) begin
                case (1'b1)
                    final_step: begin
                        state_q <= lws_pkg::LWS_DONE;
                    end
                    at_end: begin
                        pos_q <= wrap_pos;
                        pass_q <= (rep_q == '0) ? pass_q : pass_q + 8'h01;
                        load_q <= 1'b1;
                    end
                    default: begin
                        pos_q <= step_pos;
                        load_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Position after this edge, so custom_loc follows the live step at timer load
    wire hop = advance && !final_step && !clr && !stop;
    wire [9:0] pos_nx = start ? first_pos : (hop ? (at_end ? wrap_pos : step_pos) : pos_q);

    // Output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_position <= '0;
            step_load <= 1'b0;
            use_current <= 1'b0;
            custom_order <= 1'b0;
            running <= 1'b0;
            list_done <= 1'b0;
        end else begin
            step_position <= pos_nx;
            step_load <= load_q;
            use_current <= qty_q;
            custom_order <= order_q;
            running <= (state_q == lws_pkg::LWS_RUN);
            list_done <= (state_q == lws_pkg::LWS_DONE);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hrdy_q;
    assign hresp = 1'b0;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CLEAR_DIR: assert property (clr |=> !dir_q && !order_q && rep_q == 8'h01)
        else $error("clear left direction, order or count");
    AST_CLEAR_FILL: assert property (clr |=> fill_q == '0)
        else $error("clear left fill pointer");
    AST_FILL_MAX: assert property (fill_q <= 10'(MAX_ENTRIES))
        else $error("fill pointer past table end");
    AST_RB_LIMIT: assert property (rb_idx_q >= 5'(lws_pkg::RB_MAX) |-> rb_val == '0)
        else $error("readback beyond sixteen entries");
    AST_START: assert property (start |=> state_q == lws_pkg::LWS_RUN ##1 load_q == 1'b0)
        else $error("run command did not start list");
    AST_WRAP: assert property (advance && at_end && !final_step |=> pos_q == $past(wrap_pos))
        else $error("wrap did not jump to initial step");
    AST_HOLD_END: assert property (state_q == lws_pkg::LWS_DONE && !start |=> $stable(pos_q))
        else $error("output moved after completion");
    AST_DESC_END: assert property ($rose(state_q == lws_pkg::LWS_DONE) && dir_q |-> pos_q == '0)
        else $error("descending run did not end at location 0");
    AST_SKIP_DESC: assert property (advance && at_end && dir_q && !final_step |=> pos_q == last)
        else $error("skip applied in descending direction");
    AST_REP_ZERO: assert property ($rose(state_q == lws_pkg::LWS_DONE) |-> rep_q != '0)
        else $error("endless run completed");
    AST_SINGLE_HOLD: assert property (fill_q == 10'h001 |-> ticks == hold_mem[0])
        else $error("single hold time not applied");
    AST_GAPLESS: assert property (advance && !final_step |=> load_q)
        else $error("gap between steps");

    COV_DONE: cover property (state_q == lws_pkg::LWS_RUN ##1 state_q == lws_pkg::LWS_DONE);
    COV_DESC: cover property ($rose(state_q == lws_pkg::LWS_DONE) && dir_q);
    COV_SKIP: cover property (advance && at_end && skip_on && !final_step);
endmodule
`default_nettype wire

// ### verification/lws_host.sv
`timescale 1ns/100ps
`default_nettype none
module lws_host (
    // Clock
    input wire logic hclk,
    // Bus toward the sequencer
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    // Custom order table
    input wire logic [9:0] step_position,
    output lws_pkg::lws_loc_t custom_loc
);
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // Custom table swaps neighbouring locations
    assign custom_loc = step_position ^ 10'h001;
    // Bus idle at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One single word transfer, held until ready is seen
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int unsigned TC = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, lf;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] step_position;
    lws_pkg::lws_loc_t custom_loc;
    logic step_load, use_current, custom_order, running, list_done;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int hq[$], eq[$], pq[$], tq[$];

    lws_sequencer #(.TICK_CYCLES(TC), .MAX_ENTRIES(1002)) lws_sequencer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .custom_loc(custom_loc),
        .step_position(step_position), .step_load(step_load), .use_current(use_current),
        .custom_order(custom_order), .running(running), .list_done(list_done));
    lws_host lws_host_i (
        .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .step_position(step_position), .custom_loc(custom_loc));

    // Clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Step start log with cycle stamps
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (step_load === 1'b1) begin
            pq.push_back(step_position);
            tq.push_back(cyc);
        end
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        lws_host_i.bus(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        lws_host_i.bus(1'b0, a, 32'h0, rd);
        chk("reg", rd, e);
    endtask
    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Random hold in ticks, kept inside the legal span
    task automatic add_hold();
        lf = lfsr(lf);
        hq.push_back(lf % 6 + 1);
        wr(lws_pkg::ADDR_HOLD_WR, 32'(hq[$]));
    endtask
    // Expected position order of a whole run
    function automatic void exp_seq(int n, int rep, int skip, logic dn);
        int s;
        s = (skip > n - 1) ? n - 1 : skip;
        eq.delete();
        for (int r = 0; r < rep; r++)
            for (int i = 0; i < n; i++)
                if (dn) eq.push_back(n - 1 - i);
                else if (r == 0 || i >= s) eq.push_back(i);
    endfunction
    function automatic int hold_of(int loc);
        if (hq.size() == 0) return 1;
        if (loc >= hq.size()) return hq[0];
        return hq[loc];
    endfunction
    // Program, start, wait for the end, then compare order and dwell
    task automatic run_list(int n, int rep, int skip, logic dn, logic cus, logic qty);
        int loc;
        exp_seq(n, rep, skip, dn);
        pq.delete();
        tq.delete();
        wr(lws_pkg::ADDR_CTRL, {29'h0, qty, cus, dn});
        wr(lws_pkg::ADDR_STEP_CNT, 32'(n));
        wr(lws_pkg::ADDR_COUNT, 32'(skip * 256 + rep));
        wr(lws_pkg::ADDR_CMD, qty ? 32'h4 : 32'h2);
        repeat (3) @(posedge hclk);
        repeat (4000) if (list_done !== 1'b1) @(posedge hclk);
        chk("done", list_done, 1);
        chk("current", use_current, qty);
        chk("order_sel", custom_order, cus);
        chk("resp", hresp, 0);
        chk("steps", pq.size(), eq.size());
        for (int i = 0; i < eq.size(); i++) begin
            chk("position", pq[i], eq[i]);
            loc = cus ? (eq[i] ^ 1) : eq[i];
            if (i + 1 < eq.size())
                chk("dwell", tq[i + 1] - tq[i], hold_of(loc) * TC);
        end
        chk("final", step_position, eq[$]);
    endtask

    // Watchdog
    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end
    // Main sequence
    initial begin
        hresetn = 1'b0;
        lf = 32'h2bbb;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(lws_pkg::ADDR_CTRL, 0);
        rd_chk(lws_pkg::ADDR_COUNT, 1);
        rd_chk(lws_pkg::ADDR_HOLD_PTR, 0);
        rd_chk(8'h40, 0);
        wr(lws_pkg::ADDR_CTRL, 1);
        rd_chk(lws_pkg::ADDR_CTRL, 1);
        repeat (3) add_hold();
        rd_chk(lws_pkg::ADDR_HOLD_PTR, 3);
        wr(lws_pkg::ADDR_RB_START, 1);
        rd_chk(lws_pkg::ADDR_RB_DATA, hq[1]);
        rd_chk(lws_pkg::ADDR_RB_DATA, hq[2]);
        rd_chk(lws_pkg::ADDR_RB_DATA, 0);
        run_list(4, 2, 1, 0, 0, 0);
        run_list(4, 2, 1, 1, 0, 0);
        run_list(4, 1, 0, 1, 1, 0);
        wr(lws_pkg::ADDR_CTRL, 4);
        wr(lws_pkg::ADDR_CMD, 2);
        repeat (4) @(posedge hclk);
        chk("refused", running, 0);
        run_list(3, 2, 0, 0, 0, 1);
        // Endless repetition runs until the stop command
        wr(lws_pkg::ADDR_CTRL, 0);
        wr(lws_pkg::ADDR_COUNT, 0);
        wr(lws_pkg::ADDR_CMD, 2);
        repeat (200) @(posedge hclk);
        chk("endless", running, 1);
        wr(lws_pkg::ADDR_CMD, 8);
        repeat (3) @(posedge hclk);
        chk("stopped", running, 0);
        wr(lws_pkg::ADDR_CMD, 1);
        hq.delete();
        rd_chk(lws_pkg::ADDR_CTRL, 0);
        rd_chk(lws_pkg::ADDR_COUNT, 1);
        rd_chk(lws_pkg::ADDR_HOLD_PTR, 0);
        add_hold();
        run_list(3, 1, 0, 0, 0, 0);
        rd_chk(lws_pkg::ADDR_STATUS, 32'h0002_0102);
        print_verdict();
    end
endmodule
`default_nettype wire
